// ==== core/iagate_pkg.sv ====
package iagate_pkg;
  localparam int          NUM_SRC_DEF     = 8;
  localparam int          NUM_EXT_DEF     = 4;
  localparam int          PRI_W_DEF       = 4;
  localparam int          LEG_PRI_W       = 3;
  localparam logic [3:0]  IPL_RST         = 4'h0;
  localparam logic        GIE_RST         = 1'b0;
  localparam logic        CCR_MASK_RST    = 1'b1;
  localparam logic [2:0]  LEG_THR_RST     = 3'h7;
  localparam logic        SCHEME_PRIMARY  = 1'b0;
  localparam logic        SCHEME_LEGACY   = 1'b1;
  localparam logic        LEG_MODE0       = 1'b0;
  localparam logic        LEG_MODE2       = 1'b1;
  typedef enum logic [1:0] {
    IAG_IDLE   = 2'b00,
    IAG_GRANT  = 2'b01,
    IAG_WAIT   = 2'b11
  } iag_state_type;
endpackage

// ==== core/iag_src_slice.sv ====
`timescale 1ns/1ns
`default_nettype none
// One request source: peripheral gate, controller flag, enable and priority gates
module iag_src_slice #(
  parameter int PRI_W = 4
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  // Source side
  input  wire logic             periph_req,
  input  wire logic             periph_en,
  input  wire logic             hold_flag,
  input  wire logic             flag_clr,
  input  wire logic             req_enable,
  // Priority path
  input  wire logic [PRI_W-1:0] priority_val,
  input  wire logic [PRI_W-1:0] threshold,
  input  wire logic             use_threshold,
  // Results
  output logic                  flag_reg,
  output logic                  eligible
);
  wire logic gated_req = periph_req & periph_en;
  wire logic pend      = hold_flag ? flag_reg : gated_req;
  wire logic above     = !use_threshold || (priority_val > threshold);
  wire logic flag_next = gated_req | (flag_reg & ~flag_clr);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= hold_flag ? flag_next : 1'b0;
    end
  end

  assign eligible = pend & req_enable & above;
endmodule
`default_nettype wire

// ==== core/iagate_top.sv ====
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// [RULE1] Primary: maskable requests accepted only while global enable is 1.
// [RULE2] Primary: accept only if source priority strictly exceeds 4-bit threshold.
// [RULE3] Primary: per-source priority comes from software-written priority register.
// [RULE4] Primary: controller holds request flags for peripherals, pins and NMI.
// [RULE5] Primary: maskable gated by request enable; NMI by separate NMI enable.
// [RULE6] Each peripheral request passes only while its local enable is set.
// [RULE7] Primary reset: global enable 0, threshold lowest.
// [RULE8] After reset no maskable request accepted until software changes settings.
// [RULE9] Legacy mode 0: accept only while mask flag is 0; reset sets 1.
// [RULE10] Legacy mode 2: mask flag ignored.
// [RULE11] Legacy mode 2: priority must strictly exceed 3-bit threshold.
// [RULE12] Legacy mode 2: reset sets 3-bit threshold to highest value.
// [RULE13] Mode 0 uses fixed default priorities, no threshold; mode 2 uses registers.
// [RULE14] Legacy: controller holds flags only for external interrupts.
// [RULE15] Legacy: external pin requests gated by request enable bits.
// [RULE16] Primary: global enable, controller enables and peripheral enable all required.
// [RULE17] Static inputs select scheme and legacy control mode.
module iagate_top #(
  parameter int NUM_SRC = iagate_pkg::NUM_SRC_DEF,
  parameter int NUM_EXT = iagate_pkg::NUM_EXT_DEF,
  parameter int PRI_W   = iagate_pkg::PRI_W_DEF
) (
  // Clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     reset_n,
  // Static configuration
  input  wire logic                     scheme_sel,
  input  wire logic                     legacy_mode_sel,
  // Processor status writes
  input  wire logic                     gie_wr,
  input  wire logic                     gie_wdata,
  input  wire logic                     ipl_wr,
  input  wire logic [3:0]               ipl_wdata,
  input  wire logic                     ccr_mask_wr,
  input  wire logic                     ccr_mask_wdata,
  input  wire logic                     leg_thr_wr,
  input  wire logic [2:0]               leg_thr_wdata,
  // Controller registers
  input  wire logic [NUM_SRC-1:0]       request_enable_register,
  input  wire logic                     nonmaskable_enable_register,
  input  wire logic [NUM_SRC*PRI_W-1:0] source_priority_register,
  // Peripheral requests and local enables; sources 0..NUM_EXT-1 are pins
  input  wire logic [NUM_SRC-1:0]       src_req,
  input  wire logic [NUM_SRC-1:0]       src_local_en,
  input  wire logic                     nmi_req,
  // Processor acceptance
  input  wire logic                     ack,
  // Outputs
  output logic                          irq_valid,
  output logic                          nmi_valid,
  output logic [$clog2(NUM_SRC)-1:0]    irq_id,
  output logic [PRI_W-1:0]              irq_level,
  output logic [NUM_SRC-1:0]            req_flags,
  output logic                          nmi_flag,
  output logic                          gie_out,
  output logic [3:0]                    ipl_out,
  output logic                          ccr_mask_out,
  output logic [2:0]                    leg_thr_out
);
  localparam int IDW = $clog2(NUM_SRC);

  logic                 gie_reg;
  logic [3:0]           ipl_reg;
  logic                 ccr_mask_reg;
  logic [2:0]           leg_thr_reg;
  logic                 nmi_flag_reg;
  logic [NUM_SRC-1:0]   flag_q;
  logic [NUM_SRC-1:0]   elig;
  logic                 irq_valid_reg;
  logic [IDW-1:0]       irq_id_reg;
  logic [PRI_W-1:0]     irq_level_reg;
  iagate_pkg::iag_state_type state_reg;
  iagate_pkg::iag_state_type state_next;

  wire logic is_primary = (scheme_sel == iagate_pkg::SCHEME_PRIMARY);    // see [RULE17]
  wire logic is_mode2   = (legacy_mode_sel == iagate_pkg::LEG_MODE2);
  // Effective threshold, widened to the priority width
  wire logic [PRI_W-1:0] thr_eff = is_primary ? PRI_W'(ipl_reg)           // see [RULE2]
                                              : PRI_W'(leg_thr_reg);      // see [RULE11]
  wire logic use_thr = is_primary | is_mode2;                            // see [RULE13]
  // Processor-level mask
  wire logic cpu_open = is_primary ? gie_reg                              // see [RULE1]
                      : (is_mode2 ? 1'b1 : ~ccr_mask_reg);               // see [RULE9] [RULE10]

  // Processor status, reset to masked
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      gie_reg      <= iagate_pkg::GIE_RST;                                // see [RULE7] [RULE8]
      ipl_reg      <= iagate_pkg::IPL_RST;                                // see [RULE7]
      ccr_mask_reg <= iagate_pkg::CCR_MASK_RST;                           // see [RULE9]
      leg_thr_reg  <= iagate_pkg::LEG_THR_RST;                            // see [RULE12]
    end else begin
      if (gie_wr) begin
        gie_reg <= gie_wdata;
      end
      if (ipl_wr) begin
        ipl_reg <= ipl_wdata;
      end
      if (ccr_mask_wr) begin
        ccr_mask_reg <= ccr_mask_wdata;
      end
      if (leg_thr_wr) begin
        leg_thr_reg <= leg_thr_wdata;
      end
    end
  end

  // Accepted source clears its flag
  wire logic           take = (state_reg == iagate_pkg::IAG_GRANT) & ack;
  wire logic [NUM_SRC-1:0] clr_vec = take ? (NUM_SRC'(1) << irq_id_reg) : '0;

  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_src
      // Primary holds every flag; legacy only external pins
      wire logic hold = is_primary | (g < NUM_EXT);                      // see [RULE4] [RULE14]
      // Mode 0 has fixed default priority: lower index wins, no threshold
      // Legacy priorities are three bits wide, so they can never beat level 7
      wire logic [PRI_W-1:0] raw = source_priority_register[g*PRI_W +: PRI_W];
      wire logic [PRI_W-1:0] pri = !use_thr ? '0 :                        // see [RULE3] [RULE13]
        (is_primary ? raw : PRI_W'(raw[iagate_pkg::LEG_PRI_W-1:0]));      // see [RULE11]
      wire logic en = is_primary ? request_enable_register[g]            // see [RULE5]
                    : ((g < NUM_EXT) ? request_enable_register[g] : 1'b1); // see [RULE15]
      iag_src_slice #(.PRI_W(PRI_W)) u_slice (
        .sys_clk       (sys_clk),
        .reset_n       (reset_n),
        .periph_req    (src_req[g]),
        .periph_en     (src_local_en[g]),                                // see [RULE6]
        .hold_flag     (hold),
        .flag_clr      (clr_vec[g]),
        .req_enable    (en),
        .priority_val  (pri),
        .threshold     (thr_eff),
        .use_threshold (use_thr),
        .flag_reg      (flag_q[g]),
        .eligible      (elig[g])
      );
    end
  endgenerate

  // Pick highest priority eligible source; ties go to lowest index
  logic [IDW-1:0]   best_id;
  logic [PRI_W-1:0] best_pri;
  logic             best_any;
  always_comb begin
    best_id  = '0;
    best_pri = '0;
    best_any = 1'b0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (elig[i] && (!best_any || source_pri(i) > best_pri)) begin
        best_any = 1'b1;
        best_id  = IDW'(i);
        best_pri = source_pri(i);
      end
    end
  end

  function automatic logic [PRI_W-1:0] source_pri(input int idx);
    logic [PRI_W-1:0] raw_pri;
    raw_pri = source_priority_register[idx*PRI_W +: PRI_W];
    if (!use_thr) begin
      source_pri = '0;
    end else if (is_primary) begin
      source_pri = raw_pri;
    end else begin
      source_pri = PRI_W'(raw_pri[iagate_pkg::LEG_PRI_W-1:0]);
    end
  endfunction

  wire logic accept_now = best_any & cpu_open;                            // see [RULE16]

  // Nonmaskable flag held in controller in primary scheme
  wire logic nmi_gated = nmi_req & (nonmaskable_enable_register | ~is_primary); // see [RULE5]
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      nmi_flag_reg <= 1'b0;
    end else begin
      nmi_flag_reg <= nmi_gated | (nmi_flag_reg & ~(ack & nmi_flag_reg)); // see [RULE4]
    end
  end

  // Request presentation: offer, hold until ack, then two cycle gap
  always_comb begin
    case (state_reg)
      iagate_pkg::IAG_IDLE: begin
        state_next = accept_now ? iagate_pkg::IAG_GRANT : iagate_pkg::IAG_IDLE;
      end
      iagate_pkg::IAG_GRANT: begin
        state_next = ack ? iagate_pkg::IAG_WAIT : iagate_pkg::IAG_GRANT;
      end
      iagate_pkg::IAG_WAIT:  state_next = iagate_pkg::IAG_IDLE;
      default:               state_next = iagate_pkg::IAG_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg     <= iagate_pkg::IAG_IDLE;
      irq_valid_reg <= 1'b0;
      irq_id_reg    <= '0;
      irq_level_reg <= '0;
    end else begin
      state_reg     <= state_next;
      irq_valid_reg <= (state_next == iagate_pkg::IAG_GRANT);
      if (state_reg == iagate_pkg::IAG_IDLE && accept_now) begin
        irq_id_reg    <= best_id;
        irq_level_reg <= best_pri;
      end
    end
  end

  assign irq_valid    = irq_valid_reg;
  assign irq_id       = irq_id_reg;
  assign irq_level    = irq_level_reg;
  assign nmi_valid    = nmi_flag_reg;
  assign req_flags    = flag_q;
  assign nmi_flag     = nmi_flag_reg;
  assign gie_out      = gie_reg;
  assign ipl_out      = ipl_reg;
  assign ccr_mask_out = ccr_mask_reg;
  assign leg_thr_out  = leg_thr_reg;

  // Processor-level gating
  AST_GIE_BLOCKS: assert property (@(posedge sys_clk) disable iff (!reset_n) // see [RULE1]
    is_primary && !gie_reg |-> !accept_now)
    else $error("accept with gie low");
  AST_THR_STRICT: assert property (@(posedge sys_clk) disable iff (!reset_n) // see [RULE2]
    accept_now && use_thr |-> best_pri > thr_eff)
    else $error("priority not above threshold");
  AST_MODE0_MASK: assert property (@(posedge sys_clk) disable iff (!reset_n) // see [RULE9]
    !is_primary && !is_mode2 && ccr_mask_reg |-> !accept_now)
    else $error("mode0 mask ignored");
  AST_MODE2_NOMASK: assert property (@(posedge sys_clk) disable iff (!reset_n) // see [RULE10]
    !is_primary && is_mode2 && best_any |-> accept_now)
    else $error("mode2 eligible request not accepted");
  AST_MODE2_THR: assert property (@(posedge sys_clk) disable iff (!reset_n) // see [RULE11]
    !is_primary && is_mode2 && accept_now |-> best_pri > PRI_W'(leg_thr_reg))
    else $error("mode2 priority not above threshold");
  AST_MODE0_FIXED: assert property (@(posedge sys_clk) disable iff (!reset_n) // see [RULE13]
    !is_primary && !is_mode2 && elig[0] && accept_now && state_reg == iagate_pkg::IAG_IDLE
    |=> irq_id == '0)
    else $error("mode0 fixed order broken");

  // Source gating and flags
  AST_REQ_EN: assert property (@(posedge sys_clk) disable iff (!reset_n) // see [RULE5]
    is_primary && !request_enable_register[0] |-> !elig[0])
    else $error("disabled source eligible");
  AST_NMI_EN: assert property (@(posedge sys_clk) disable iff (!reset_n) // see [RULE5]
    is_primary && !nmi_flag_reg && !(nmi_req && nonmaskable_enable_register) |=> !nmi_flag_reg)
    else $error("nmi set while disabled");
  AST_NMI_SET: assert property (@(posedge sys_clk) disable iff (!reset_n) // see [RULE4]
    is_primary && nmi_req && nonmaskable_enable_register |=> nmi_flag_reg)
    else $error("nmi flag not set");
  AST_FLAG_SET: assert property (@(posedge sys_clk) disable iff (!reset_n) // see [RULE4]
    src_req[0] && src_local_en[0] |=> flag_q[0])
    else $error("request flag not set");
  AST_LOCAL_EN: assert property (@(posedge sys_clk) disable iff (!reset_n) // see [RULE6]
    !src_local_en[0] && !flag_q[0] |=> !flag_q[0])
    else $error("flag set without local enable");
  AST_PERIPH_GATE: assert property (@(posedge sys_clk) disable iff (!reset_n) // see [RULE6]
    !is_primary && !src_local_en[NUM_SRC-1] |-> !elig[NUM_SRC-1])
    else $error("internal source passed without local enable");
  AST_LEG_INT_NOFLAG: assert property (@(posedge sys_clk) disable iff (!reset_n) // see [RULE14]
    !is_primary |-> flag_q[NUM_SRC-1:NUM_EXT] == '0)
    else $error("legacy internal flag held");
  AST_LEG_PIN_EN: assert property (@(posedge sys_clk) disable iff (!reset_n) // see [RULE15]
    !is_primary && !request_enable_register[0] |-> !elig[0])
    else $error("legacy pin eligible while disabled");

  // Offer handshake
  AST_OFFER: assert property (@(posedge sys_clk) disable iff (!reset_n) // see [RULE16]
    state_reg == iagate_pkg::IAG_IDLE && accept_now |=> irq_valid ##0 irq_id == $past(best_id))
    else $error("offer wrong");
  AST_HOLD: assert property (@(posedge sys_clk) disable iff (!reset_n) // see [RULE16]
    irq_valid && !ack |=> irq_valid && $stable(irq_id))
    else $error("offer dropped");
  AST_GAP: assert property (@(posedge sys_clk) disable iff (!reset_n) // see [RULE16]
    take |=> !irq_valid ##1 !irq_valid)
    else $error("offer without idle gap");

  // Reset state
  AST_RESET_MASK: assert property (@(posedge sys_clk) // see [RULE8]
    $rose(reset_n) |-> !accept_now)
    else $error("accept right after reset");
  AST_RST_PRIMARY: assert property (@(posedge sys_clk) // see [RULE7]
    $rose(reset_n) |-> gie_reg == iagate_pkg::GIE_RST && ipl_reg == iagate_pkg::IPL_RST)
    else $error("primary reset values wrong");
  AST_RST_LEGACY: assert property (@(posedge sys_clk) // see [RULE12]
    $rose(reset_n) |-> leg_thr_reg == iagate_pkg::LEG_THR_RST
                       && ccr_mask_reg == iagate_pkg::CCR_MASK_RST)
    else $error("legacy reset values wrong");

  COV_GRANT: cover property (@(posedge sys_clk) disable iff (!reset_n) take);
  COV_MODE2: cover property (@(posedge sys_clk) disable iff (!reset_n)
    !is_primary && is_mode2 && accept_now);
  COV_MODE0: cover property (@(posedge sys_clk) disable iff (!reset_n)
    !is_primary && !is_mode2 && take);
  COV_PRIMARY: cover property (@(posedge sys_clk) disable iff (!reset_n)
    is_primary && take);
  COV_NMI: cover property (@(posedge sys_clk) disable iff (!reset_n) nmi_flag_reg);
endmodule
`default_nettype wire

// ==== verif/iag_cpu_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// Processor side: acks an offer wait_cycles+1 clocks after it appears
module iag_cpu_model (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  // Offer from the gate and ack delay
  input  wire logic       irq_valid,
  input  wire logic       nmi_valid,
  input  wire logic [2:0] irq_id,
  input  wire logic [3:0] wait_cycles,
  // Acceptance and record
  output logic            ack,
  output logic [7:0]      taken_count,
  output logic [2:0]      last_id
);
  logic [3:0] wait_reg;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack         <= 1'b0;
      wait_reg    <= 4'h0;
      taken_count <= 8'h00;
      last_id     <= 3'h0;
    end else if (ack) begin
      ack         <= 1'b0;
      wait_reg    <= 4'h0;
      taken_count <= taken_count + 8'h01;
      last_id     <= irq_id;
    end else if (irq_valid || nmi_valid) begin
      // Ack only while an offer stands
      ack      <= (wait_reg == wait_cycles);
      wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ==== verif/interrupt_acceptance_gate_test.sv ====
`timescale 1ns/1ns
`default_nettype none
module interrupt_acceptance_gate_test;
  logic        sys_clk, reset_n, scheme_sel, legacy_mode_sel, gie_wr, gie_wdata;
  logic        ipl_wr, ccr_mask_wr, ccr_mask_wdata, leg_thr_wr, nmi_req, ack;
  logic        nonmaskable_enable_register, irq_valid, nmi_valid, nmi_flag;
  logic        gie_out, ccr_mask_out;
  logic [3:0]  ipl_wdata, wait_cycles, ipl_out, irq_level;
  logic [2:0]  leg_thr_wdata, irq_id, last_id, leg_thr_out;
  logic [7:0]  request_enable_register, src_req, src_local_en, req_flags, taken_count;
  logic [31:0] source_priority_register;
  int          bad_count, cmp_count, exp_taken;

  iagate_top dut_u (
    .sys_clk(sys_clk), .reset_n(reset_n), .scheme_sel(scheme_sel),
    .legacy_mode_sel(legacy_mode_sel), .gie_wr(gie_wr), .gie_wdata(gie_wdata),
    .ipl_wr(ipl_wr), .ipl_wdata(ipl_wdata), .ccr_mask_wr(ccr_mask_wr),
    .ccr_mask_wdata(ccr_mask_wdata), .leg_thr_wr(leg_thr_wr), .leg_thr_wdata(leg_thr_wdata),
    .request_enable_register(request_enable_register),
    .nonmaskable_enable_register(nonmaskable_enable_register),
    .source_priority_register(source_priority_register), .src_req(src_req),
    .src_local_en(src_local_en), .nmi_req(nmi_req), .ack(ack), .irq_valid(irq_valid),
    .nmi_valid(nmi_valid), .irq_id(irq_id), .irq_level(irq_level), .req_flags(req_flags),
    .nmi_flag(nmi_flag), .gie_out(gie_out), .ipl_out(ipl_out),
    .ccr_mask_out(ccr_mask_out), .leg_thr_out(leg_thr_out)
  );
  iag_cpu_model cpu_u (
    .sys_clk(sys_clk), .reset_n(reset_n), .irq_valid(irq_valid), .nmi_valid(nmi_valid),
    .irq_id(irq_id), .wait_cycles(wait_cycles), .ack(ack), .taken_count(taken_count),
    .last_id(last_id)
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic settle;
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task automatic do_reset(input logic sch, input logic mode);
    reset_n <= 1'b0;
    @(posedge sys_clk);
    {scheme_sel, legacy_mode_sel, wait_cycles} <= {sch, mode, 4'h0};
    {gie_wr, gie_wdata, ipl_wr, ccr_mask_wr, ccr_mask_wdata, leg_thr_wr, nmi_req} <= 7'h00;
    {ipl_wdata, leg_thr_wdata, src_req} <= 15'h0000;
    {request_enable_register, src_local_en, nonmaskable_enable_register} <= 17'h1ffff;
    source_priority_register <= {8{4'h5}};
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    exp_taken = 0;
    @(negedge sys_clk);
  endtask
  // Selects 0 enable, 1 threshold, 2 mask flag, 3 legacy threshold
  task automatic write(input int sel, input logic [3:0] v);
    @(posedge sys_clk);
    {gie_wdata, ccr_mask_wdata, ipl_wdata, leg_thr_wdata} <= {v[0], v[0], v, v[2:0]};
    {gie_wr, ipl_wr, ccr_mask_wr, leg_thr_wr} <= 4'h8 >> sel;
    @(posedge sys_clk);
    {gie_wr, ipl_wr, ccr_mask_wr, leg_thr_wr} <= 4'h0;
  endtask
  task automatic prio(input int k, input logic [3:0] v, input logic [3:0] w);
    @(posedge sys_clk);
    source_priority_register[k*4 +: 4] <= v;
    wait_cycles <= w;
    settle;
  endtask
  task automatic fire(input logic [8:0] bits);
    @(posedge sys_clk);
    {nmi_req, src_req} <= bits;
    @(posedge sys_clk);
    {nmi_req, src_req} <= 9'h000;
    settle;
  endtask
  task automatic took(input int n, input logic [2:0] id);
    exp_taken += n;
    check(taken_count, exp_taken[7:0]);
    if (n > 0)
      check({5'h00, last_id}, {5'h00, id});
  endtask

  task automatic t_primary;
    do_reset(iagate_pkg::SCHEME_PRIMARY, iagate_pkg::LEG_MODE0);
    check({3'h0, gie_out, ipl_out}, 8'h00);
    check({4'h0, ccr_mask_out, leg_thr_out}, 8'h0f);
    fire(9'h004);
    took(0, 3'h0);
    check(req_flags, 8'h04);
    write(0, 4'h1);
    settle;
    took(1, 3'h2);
    check(req_flags, 8'h00);
    write(1, 4'h5);
    fire(9'h008);
    took(0, 3'h0);
    check({4'h0, ipl_out}, 8'h05);
    prio(3, 4'h6, 4'h6);
    check({irq_valid, irq_id, irq_level}, 8'hb6);
    settle;
    took(1, 3'h3);
    $display("primary scheme test done");
  endtask
  task automatic t_gates;
    do_reset(iagate_pkg::SCHEME_PRIMARY, iagate_pkg::LEG_MODE0);
    write(0, 4'h1);
    @(posedge sys_clk);
    {request_enable_register, src_local_en} <= 16'hfdef;
    nonmaskable_enable_register <= 1'b0;
    fire(9'h112);
    took(0, 3'h0);
    check(req_flags & 8'h10, 8'h00);
    @(posedge sys_clk);
    {nonmaskable_enable_register, wait_cycles} <= 5'h18;
    fire(9'h100);
    check({6'h00, nmi_flag, nmi_valid}, 8'h03);
    $display("enable gate test done");
  endtask
  task automatic t_mode0;
    do_reset(iagate_pkg::SCHEME_LEGACY, iagate_pkg::LEG_MODE0);
    @(posedge sys_clk);
    source_priority_register <= 32'h00000f10;
    request_enable_register <= 8'hf7;
    fire(9'h02e);
    took(0, 3'h0);
    check(req_flags & 8'h26, 8'h06);
    write(2, 4'h0);
    settle;
    settle;
    took(2, 3'h2);
    $display("legacy mode 0 test done");
  endtask
  task automatic t_mode2;
    do_reset(iagate_pkg::SCHEME_LEGACY, iagate_pkg::LEG_MODE2);
    prio(0, 4'hf, 4'h0);
    fire(9'h001);
    took(0, 3'h0);
    prio(0, 4'h3, 4'h0);
    write(3, 4'h3);
    settle;
    took(0, 3'h0);
    check({5'h00, leg_thr_out}, 8'h03);
    prio(0, 4'h4, 4'h0);
    took(1, 3'h0);
    $display("legacy mode 2 test done");
  endtask

  initial begin
    bad_count = 0;
    cmp_count = 0;
    t_primary;
    t_gates;
    t_mode0;
    t_mode2;
    results;
  end
  initial begin
    repeat (4000) @(posedge sys_clk);
    bad_count++;
    results;
  end
endmodule
`default_nettype wire
